/* hdl/calibration_pin_sequencer.sv */
// calibration request sequencer with heartbeat, scaling, storage and fault signalling
`default_nettype none
`include "cal_consts.svh"

// Function
// - Automatic mode: a low request held 12 s re-references the reading.
// - Automatic hold shows high, rapid blink, high, low, then normal cycling.
// - Keep an automatic reference, default 20.7 percent, changeable by strobe.
// - Every new calibration value is written out to non-volatile storage.
// - A setting chooses automatic or manual potentiometer calibration.
// - Manual mode: first 5 s low hold enters trim, shown by 1 Hz blinking.
// - Second 5 s hold finishes: rapid blink, high, low, then normal cycling.
// - After calibration, readings are scaled so the gas reads its reference.
// - Sensor fault shows three short and one long blink, or steady off.
// - Sensor fault sends an error code and forces analog outputs to zero.
// - Reading is reported as a five-character ASCII value.
// - Serial streaming is suspended while a calibration is in progress.
module calibration_pin_sequencer #(
	parameter int          TICK_CYCLES  = `CAL_TICK_NS / `CAL_CLK_PERIOD_NS,
	parameter logic [15:0] AUTO_HOLD_MS = `CAL_AUTO_HOLD_MS,
	parameter logic [15:0] MAN_HOLD_MS  = `CAL_MAN_HOLD_MS,
	parameter logic [15:0] DEBOUNCE_MS  = `CAL_DEBOUNCE_MS
) (
	input  wire logic        clk_sys,
	input  wire logic        reset_n,
	input  wire logic        clk_en,
	input  wire logic        cal_req_n,
	input  wire logic        cal_mode_manual,
	input  wire logic        ref_set,
	input  wire logic [15:0] ref_set_value,
	input  wire logic [15:0] manual_trim_potentiometer,
	input  wire logic [15:0] raw_reading,
	input  wire logic        sensor_fault,
	input  wire logic        fault_dark_sel,
	input  wire logic        nv_load_valid,
	input  wire logic [47:0] nv_load_data,
	output var  logic        nv_write,
	output var  logic [47:0] nv_wdata,
	output var  logic        heartbeat,
	output var  logic        led,
	output var  logic [15:0] scaled_reading,
	output var  logic [39:0] ascii_value,
	output logic             stream_enable,
	output var  logic        error_valid,
	output var  logic [7:0]  error_code,
	output var  logic        analog_default,
	output var  logic [15:0] analog_value
);
	localparam logic [15:0] AUTO_PHASE = AUTO_HOLD_MS / 16'h0004;
	localparam logic [15:0] MAN_RAPID  = 16'((32'(MAN_HOLD_MS) * 3) / 5);
	localparam logic [15:0] MAN_HIGH   = 16'((32'(MAN_HOLD_MS) * 4) / 5);
	localparam logic [15:0] FS         = `CAL_FAULT_SHORT_MS;

	cal_pkg::cal_state_t  state;
	cal_pkg::cal_record_t record;
	logic                 tick_ms;
	logic [15:0]          phase_ms;
	logic                 commit;
	logic                 fault_seen;
	logic                 next_heartbeat;
	logic                 pat_normal;
	logic                 pat_slow;
	logic                 pat_rapid;
	logic                 pat_fault;
	logic [15:0]          fault_ms;
	logic [31:0]          quotient;
	logic [15:0]          clamped;

	hold_if hold ();

	pulse_timebase #(
		.DIV (TICK_CYCLES)
	) u_timebase (
		.clk_sys (clk_sys),
		.reset_n (reset_n),
		.clk_en  (clk_en),
		.tick    (tick_ms)
	);

	hold_timer #(
		.DEBOUNCE_MS (DEBOUNCE_MS)
	) u_hold (
		.clk_sys   (clk_sys),
		.reset_n   (reset_n),
		.clk_en    (clk_en),
		.tick_ms   (tick_ms),
		.cal_req_n (cal_req_n),
		.hold      (hold)
	);

	function automatic logic blink(input logic [15:0] ms, input logic [15:0] half);
		logic [15:0] q;
		q = ms / half;
		return q[0];
	endfunction

	// completion of either calibration kind
	always_comb begin
		commit = 1'b0;
		if (!sensor_fault && hold.low) begin
			if (state == cal_pkg::ST_AUTO && hold.low_ms >= AUTO_HOLD_MS) begin
				commit = 1'b1;
			end
			if (state == cal_pkg::ST_MAN_DONE && hold.low_ms >= MAN_HOLD_MS) begin
				commit = 1'b1;
			end
		end
	end

	// sequence of calibration states
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			state <= cal_pkg::ST_IDLE;
		end else if (clk_en) begin
			if (sensor_fault) begin
				state <= cal_pkg::ST_IDLE;
			end else begin
				case (state)
					cal_pkg::ST_IDLE: begin
						if (hold.low) begin
							state <= cal_mode_manual ? cal_pkg::ST_MAN_ARM : cal_pkg::ST_AUTO;
						end
					end
					cal_pkg::ST_AUTO: begin
						if (!hold.low) begin
							state <= cal_pkg::ST_IDLE;
						end else if (commit) begin
							state <= cal_pkg::ST_WAIT_REL;
						end
					end
					cal_pkg::ST_MAN_ARM: begin
						if (!hold.low) begin
							state <= cal_pkg::ST_IDLE;
						end else if (hold.low_ms >= MAN_HOLD_MS) begin
							state <= cal_pkg::ST_MAN_REL;
						end
					end
					cal_pkg::ST_MAN_REL: begin
						if (!hold.low) begin
							state <= cal_pkg::ST_MAN_TRIM;
						end
					end
					cal_pkg::ST_MAN_TRIM: begin
						if (hold.low) begin
							state <= cal_pkg::ST_MAN_DONE;
						end
					end
					cal_pkg::ST_MAN_DONE: begin
						if (!hold.low) begin
							state <= cal_pkg::ST_MAN_TRIM;
						end else if (commit) begin
							state <= cal_pkg::ST_WAIT_REL;
						end
					end
					cal_pkg::ST_WAIT_REL: begin
						if (!hold.low) begin
							state <= cal_pkg::ST_IDLE;
						end
					end
					default: begin
						state <= cal_pkg::ST_IDLE;
					end
				endcase
			end
		end
	end

	// calibration record and its storage
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			record.auto_ref <= `CAL_REF_DEFAULT;
			record.cal_ref  <= `CAL_REF_DEFAULT;
			record.cal_raw  <= `CAL_RAW_DEFAULT;
			nv_write        <= 1'b0;
			nv_wdata        <= '0;
		end else if (clk_en) begin
			nv_write <= 1'b0;
			if (nv_load_valid) begin
				record <= nv_load_data;
			end
			if (ref_set) begin
				record.auto_ref <= ref_set_value;
				nv_write        <= 1'b1;
				nv_wdata        <= {ref_set_value, record.cal_ref, record.cal_raw};
			end
			if (commit) begin
				record.cal_ref <= (state == cal_pkg::ST_AUTO) ? record.auto_ref : manual_trim_potentiometer;
				record.cal_raw <= (raw_reading == 16'h0000) ? 16'h0001 : raw_reading;
				nv_write       <= 1'b1;
				nv_wdata       <= {ref_set ? ref_set_value : record.auto_ref,
					(state == cal_pkg::ST_AUTO) ? record.auto_ref : manual_trim_potentiometer,
					(raw_reading == 16'h0000) ? 16'h0001 : raw_reading};
			end
		end
	end

	always_comb begin
		quotient = (32'(raw_reading) * 32'(record.cal_ref)) / 32'(record.cal_raw);
		clamped  = (quotient > 32'(`CAL_READING_MAX)) ? `CAL_READING_MAX : quotient[15:0];
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			scaled_reading <= '0;
			ascii_value    <= '0;
		end else if (clk_en) begin
			scaled_reading <= clamped;
			ascii_value <= {`CAL_ASCII_ZERO + 8'(clamped / 16'd1000),
				`CAL_ASCII_ZERO + 8'((clamped / 16'd100) % 16'd10),
				`CAL_ASCII_DOT,
				`CAL_ASCII_ZERO + 8'((clamped / 16'd10) % 16'd10),
				`CAL_ASCII_ZERO + 8'(clamped % 16'd10)};
		end
	end

	// fault forces analog default and reports a code
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			fault_seen     <= 1'b0;
			error_valid    <= 1'b0;
			error_code     <= '0;
			analog_default <= 1'b0;
			analog_value   <= '0;
		end else if (clk_en) begin
			fault_seen     <= sensor_fault;
			error_valid    <= sensor_fault && !fault_seen;
			error_code     <= sensor_fault ? `CAL_ERROR_CODE : 8'h00;
			analog_default <= sensor_fault;
			analog_value   <= sensor_fault ? 16'h0000 : clamped;
		end
	end

	// streaming only while idle and healthy
	assign stream_enable = (state == cal_pkg::ST_IDLE) && !sensor_fault;

	// shared blink phase, wraps on a multiple of every pattern period
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			phase_ms <= '0;
		end else if (clk_en && tick_ms) begin
			phase_ms <= (phase_ms >= `CAL_PHASE_WRAP_MS - 16'h0001) ? 16'h0000 : phase_ms + 16'h0001;
		end
	end

	always_comb begin
		pat_normal = blink(phase_ms, `CAL_NORMAL_HALF_MS);
		pat_slow   = !blink(phase_ms, `CAL_SLOW_HALF_MS);
		pat_rapid  = !blink(phase_ms, `CAL_RAPID_HALF_MS);
		fault_ms   = phase_ms % `CAL_FAULT_PERIOD_MS;
		pat_fault  = (fault_ms < FS)
			|| (fault_ms >= 16'(FS * 2) && fault_ms < 16'(FS * 3))
			|| (fault_ms >= 16'(FS * 4) && fault_ms < 16'(FS * 5))
			|| (fault_ms >= 16'(FS * 6) && fault_ms < 16'(FS * 6 + `CAL_FAULT_LONG_MS));
	end

	always_comb begin
		next_heartbeat = 1'b0;
		case (state)
			cal_pkg::ST_IDLE: begin
				if (sensor_fault) begin
					next_heartbeat = fault_dark_sel ? 1'b0 : pat_fault;
				end else begin
					next_heartbeat = pat_normal;
				end
			end
			cal_pkg::ST_MAN_ARM, cal_pkg::ST_WAIT_REL: begin
				next_heartbeat = pat_normal;
			end
			cal_pkg::ST_AUTO: begin
				if (hold.low_ms < AUTO_PHASE) begin
					next_heartbeat = 1'b1;
				end else if (hold.low_ms < 16'(AUTO_PHASE * 2)) begin
					next_heartbeat = pat_rapid;
				end else if (hold.low_ms < 16'(AUTO_PHASE * 3)) begin
					next_heartbeat = 1'b1;
				end else begin
					next_heartbeat = 1'b0;
				end
			end
			cal_pkg::ST_MAN_REL, cal_pkg::ST_MAN_TRIM: begin
				next_heartbeat = pat_slow;
			end
			cal_pkg::ST_MAN_DONE: begin
				if (hold.low_ms < MAN_RAPID) begin
					next_heartbeat = pat_rapid;
				end else if (hold.low_ms < MAN_HIGH) begin
					next_heartbeat = 1'b1;
				end else begin
					next_heartbeat = 1'b0;
				end
			end
			default: begin
				next_heartbeat = 1'b0;
			end
		endcase
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			heartbeat <= 1'b0;
			led       <= 1'b0;
		end else if (clk_en) begin
			heartbeat <= next_heartbeat;
			led       <= next_heartbeat;
		end
	end

	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!reset_n);

	auto_commit_a: assert property ((clk_en && state == cal_pkg::ST_AUTO && hold.low && !sensor_fault
		&& hold.low_ms >= AUTO_HOLD_MS) |=> (state == cal_pkg::ST_WAIT_REL && nv_write))
		else $error("automatic hold did not commit");
	auto_steady_a: assert property ((clk_en && state == cal_pkg::ST_AUTO && !sensor_fault
		&& hold.low_ms < AUTO_PHASE) |=> heartbeat)
		else $error("heartbeat not high at start of automatic hold");
	auto_low_a: assert property ((clk_en && state == cal_pkg::ST_AUTO && !sensor_fault
		&& hold.low_ms >= 16'(AUTO_PHASE * 3)) |=> !heartbeat)
		else $error("heartbeat not low at end of automatic hold");
	ref_update_a: assert property ((clk_en && ref_set && !commit && !nv_load_valid)
		|=> (record.auto_ref == $past(ref_set_value) && nv_write))
		else $error("reference change not taken or not stored");
	nv_store_a: assert property ((clk_en && commit && raw_reading != 16'h0000)
		|=> (nv_write && nv_wdata[15:0] == $past(raw_reading)))
		else $error("calibration not written to storage");
	mode_sel_a: assert property ((clk_en && state == cal_pkg::ST_IDLE && hold.low && !sensor_fault)
		|=> (state == ($past(cal_mode_manual) ? cal_pkg::ST_MAN_ARM : cal_pkg::ST_AUTO)))
		else $error("calibration mode setting ignored");
	man_entry_a: assert property ((clk_en && state == cal_pkg::ST_MAN_ARM && hold.low && !sensor_fault
		&& hold.low_ms >= MAN_HOLD_MS) |=> state == cal_pkg::ST_MAN_REL)
		else $error("manual entry hold not recognised");
	man_finish_a: assert property ((clk_en && state == cal_pkg::ST_MAN_DONE && hold.low && !sensor_fault
		&& hold.low_ms >= MAN_HOLD_MS) |=> (state == cal_pkg::ST_WAIT_REL
		&& record.cal_ref == $past(manual_trim_potentiometer)))
		else $error("manual finish hold did not commit the trim");
	fault_dark_a: assert property ((clk_en && sensor_fault && fault_dark_sel && state == cal_pkg::ST_IDLE)
		|=> !heartbeat)
		else $error("dark fault pattern not off");
	fault_default_a: assert property ((clk_en && sensor_fault)
		|=> (analog_default && analog_value == 16'h0000 && error_code == `CAL_ERROR_CODE))
		else $error("fault did not force analog defaults");
	ascii_dot_a: assert property (clk_en |=> ascii_value[23:16] == `CAL_ASCII_DOT)
		else $error("ascii reading lost its decimal point");
	stream_hold_a: assert property ((state != cal_pkg::ST_IDLE) |-> !stream_enable)
		else $error("streaming active during calibration");

	auto_done_c: cover property (state == cal_pkg::ST_AUTO ##1 state == cal_pkg::ST_WAIT_REL);
	manual_done_c: cover property (state == cal_pkg::ST_MAN_DONE ##1 state == cal_pkg::ST_WAIT_REL);
	fault_seen_c: cover property (error_valid);

endmodule

`default_nettype wire

/* hdl/cal_consts.svh */
// timing counts, reset values and codes of the calibration pin sequencer
`ifndef CAL_CONSTS_SVH
`define CAL_CONSTS_SVH

`define CAL_CLK_PERIOD_NS   10
`define CAL_TICK_NS         1000000

`define CAL_DEBOUNCE_MS     16'h0014
`define CAL_AUTO_HOLD_MS    16'h2ee0
`define CAL_MAN_HOLD_MS     16'h1388

`define CAL_RAPID_HALF_MS   16'h0064
`define CAL_SLOW_HALF_MS    16'h01f4
`define CAL_NORMAL_HALF_MS  16'h03e8
`define CAL_FAULT_SHORT_MS  16'h00c8
`define CAL_FAULT_LONG_MS   16'h0320
`define CAL_FAULT_PERIOD_MS 16'h0960
`define CAL_PHASE_WRAP_MS   16'h2ee0

`define CAL_REF_DEFAULT     16'h0816
`define CAL_RAW_DEFAULT     16'h0816
`define CAL_READING_MAX     16'h270f

`define CAL_ERROR_CODE      8'h45
`define CAL_ASCII_ZERO      8'h30
`define CAL_ASCII_DOT       8'h2e

`endif

/* hdl/cal_pkg.sv */
// types shared by the calibration pin sequencer
`default_nettype none

package cal_pkg;

	typedef enum logic [6:0] {
		ST_IDLE     = 7'b0000001,
		ST_AUTO     = 7'b0000010,
		ST_MAN_ARM  = 7'b0000100,
		ST_MAN_REL  = 7'b0001000,
		ST_MAN_TRIM = 7'b0010000,
		ST_MAN_DONE = 7'b0100000,
		ST_WAIT_REL = 7'b1000000
	} cal_state_t;

	typedef struct packed {
		logic [15:0] auto_ref;
		logic [15:0] cal_ref;
		logic [15:0] cal_raw;
	} cal_record_t;

endpackage

`default_nettype wire

/* hdl/hold_if.sv */
// debounced calibration input and its low duration
`default_nettype none

interface hold_if;
	logic        low;
	logic [15:0] low_ms;

	modport timer (output low, output low_ms);
	modport user  (input low, input low_ms);
endinterface

`default_nettype wire

/* hdl/pulse_timebase.sv */
// divider that emits a one-cycle tick every DIV enabled cycles
`default_nettype none

module pulse_timebase #(
	parameter int DIV = 100000
) (
	input  wire logic clk_sys,
	input  wire logic reset_n,
	input  wire logic clk_en,
	output var  logic tick
);
	localparam int CW = (DIV > 1) ? $clog2(DIV) : 1;

	logic [CW-1:0] count;

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			count <= '0;
			tick  <= 1'b0;
		end else if (clk_en) begin
			if (count == CW'(DIV - 1)) begin
				count <= '0;
				tick  <= 1'b1;
			end else begin
				count <= count + 1'b1;
				tick  <= 1'b0;
			end
		end
	end

	tick_period_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
		(clk_en && tick && DIV > 1) |=> !tick)
		else $error("timebase tick lasted more than one cycle");

endmodule

`default_nettype wire

/* hdl/hold_timer.sv */
// debounces the calibration request and measures how long it is held low
`default_nettype none
`include "cal_consts.svh"

module hold_timer #(
	parameter logic [15:0] DEBOUNCE_MS = `CAL_DEBOUNCE_MS
) (
	input  wire logic clk_sys,
	input  wire logic reset_n,
	input  wire logic clk_en,
	input  wire logic tick_ms,
	input  wire logic cal_req_n,
	hold_if.timer     hold
);
	logic [15:0] settle_ms;

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			hold.low  <= 1'b0;
			settle_ms <= '0;
		end else if (clk_en) begin
			if (!cal_req_n == hold.low) begin
				settle_ms <= '0;
			end else if (tick_ms) begin
				if (settle_ms >= DEBOUNCE_MS - 16'h0001) begin
					hold.low  <= !cal_req_n;
					settle_ms <= '0;
				end else begin
					settle_ms <= settle_ms + 16'h0001;
				end
			end
		end
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			hold.low_ms <= '0;
		end else if (clk_en) begin
			if (!hold.low) begin
				hold.low_ms <= '0;
			end else if (tick_ms && hold.low_ms != 16'hffff) begin
				hold.low_ms <= hold.low_ms + 16'h0001;
			end
		end
	end

	debounce_hold_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
		(clk_en && !cal_req_n == hold.low) |=> (hold.low == $past(hold.low)))
		else $error("debounced level changed while input agreed with it");

endmodule

`default_nettype wire

/* test/process_controller.sv */
// controller model that drives the calibration request and times the heartbeat
`default_nettype none

module process_controller #(
	parameter int TICK      = 10,
	parameter int SETTLE_MS = 1
) (
	input  wire logic clk_sys,
	input  wire logic heartbeat,
	output var  logic cal_req_n
);
	timeunit 1ns;
	timeprecision 1ps;

	logic ready;

	initial begin
		cal_req_n = 1'b1;
		ready = 1'b0;
		repeat (SETTLE_MS * TICK) @(posedge clk_sys);
		ready = 1'b1;
	end

	task automatic press(input int ms);
		wait (ready);
		@(posedge clk_sys);
		#1 cal_req_n = 1'b0;
		repeat (ms * TICK) @(posedge clk_sys);
		#1 cal_req_n = 1'b1;
	endtask

	// cycles between the next two heartbeat edges
	task automatic hb_half(output int n);
		logic last;
		int   c;
		@(posedge clk_sys);
		#1;
		last = heartbeat;
		for (c = 0; c < 8000 && heartbeat === last; c++) begin
			@(posedge clk_sys);
			#1;
		end
		last = heartbeat;
		for (c = 0; c < 8000 && heartbeat === last; c++) begin
			@(posedge clk_sys);
			#1;
		end
		n = c;
	endtask
endmodule

`default_nettype wire

/* test/calibration_pin_sequencer_bench.sv */
// self-checking bench of the calibration pin sequencer
`default_nettype none
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin n_fail++; $display("[FAIL] t=%0t got=%h exp=%h", $time, (a), (b)); end end

module calibration_pin_sequencer_bench;
	timeunit 1ns;
	timeprecision 1ps;

	localparam int TICK = 10;

	logic        clk_sys;
	logic        reset_n;
	logic        clk_en;
	logic        cal_req_n;
	logic        cal_mode_manual;
	logic        ref_set;
	logic        sensor_fault;
	logic        fault_dark_sel;
	logic        nv_load_valid;
	logic        nv_write;
	logic        heartbeat;
	logic        led;
	logic        stream_enable;
	logic        error_valid;
	logic        analog_default;
	logic [7:0]  error_code;
	logic [15:0] ref_set_value;
	logic [15:0] manual_trim_potentiometer;
	logic [15:0] raw_reading;
	logic [15:0] scaled_reading;
	logic [15:0] analog_value;
	logic [39:0] ascii_value;
	logic [47:0] nv_load_data;
	logic [47:0] nv_wdata;
	logic [47:0] nv_last;
	logic [31:0] seed;
	logic [31:0] r32;
	logic [15:0] ref_val;
	logic [15:0] raw0;
	logic [15:0] raw1;
	int          n_fail;
	int          cmp_count;
	int          nv_count;
	int          n;

	calibration_pin_sequencer #(
		.TICK_CYCLES  (TICK),
		.AUTO_HOLD_MS (16'h0028),
		.MAN_HOLD_MS  (16'h0014),
		.DEBOUNCE_MS  (16'h0002)
	) i_calibration_pin_sequencer (
		.clk_sys                   (clk_sys),
		.reset_n                   (reset_n),
		.clk_en                    (clk_en),
		.cal_req_n                 (cal_req_n),
		.cal_mode_manual           (cal_mode_manual),
		.ref_set                   (ref_set),
		.ref_set_value             (ref_set_value),
		.manual_trim_potentiometer (manual_trim_potentiometer),
		.raw_reading               (raw_reading),
		.sensor_fault              (sensor_fault),
		.fault_dark_sel            (fault_dark_sel),
		.nv_load_valid             (nv_load_valid),
		.nv_load_data              (nv_load_data),
		.nv_write                  (nv_write),
		.nv_wdata                  (nv_wdata),
		.heartbeat                 (heartbeat),
		.led                       (led),
		.scaled_reading            (scaled_reading),
		.ascii_value               (ascii_value),
		.stream_enable             (stream_enable),
		.error_valid               (error_valid),
		.error_code                (error_code),
		.analog_default            (analog_default),
		.analog_value              (analog_value)
	);

	process_controller i_process_controller (
		.clk_sys   (clk_sys),
		.heartbeat (heartbeat),
		.cal_req_n (cal_req_n)
	);

	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	function automatic logic [15:0] scale(input logic [15:0] r, input logic [15:0] c, input logic [15:0] d);
		logic [31:0] q;
		q = ({16'h0000, r} * {16'h0000, c}) / {16'h0000, d};
		return (q > 32'h0000270f) ? 16'h270f : q[15:0];
	endfunction

	function automatic logic [39:0] to_ascii(input logic [15:0] v);
		return {8'h30 + 8'(v / 1000), 8'h30 + 8'(v / 100 % 10), 8'h2e, 8'h30 + 8'(v / 10 % 10), 8'h30 + 8'(v % 10)};
	endfunction

	task automatic wait_ms(input int ms);
		repeat (ms * TICK) @(posedge clk_sys);
		#1;
	endtask

	task automatic chk_scale(input logic [15:0] r, input logic [15:0] c, input logic [15:0] d);
		raw_reading = r;
		repeat (3) @(posedge clk_sys);
		#1;
		`CHK(scaled_reading, scale(r, c, d))
		`CHK(ascii_value, to_ascii(scale(r, c, d)))
	endtask

	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end

	// store pulses seen on the storage port
	always begin
		@(posedge clk_sys);
		#1;
		if (nv_write === 1'b1) begin
			nv_count++;
			nv_last = nv_wdata;
		end
	end

	initial begin
		#1_000_000;
		n_fail++;
		end_of_test();
	end

	initial begin
		seed = 32'h00016dfa;
		n_fail = 0;
		cmp_count = 0;
		nv_count = 0;
		reset_n = 1'b0;
		clk_en = 1'b1;
		cal_mode_manual = 1'b0;
		ref_set = 1'b0;
		ref_set_value = 16'h0000;
		manual_trim_potentiometer = 16'h0816;
		raw_reading = 16'h0816;
		sensor_fault = 1'b0;
		fault_dark_sel = 1'b0;
		nv_load_valid = 1'b0;
		nv_load_data = 48'h0;
		repeat (2) @(posedge clk_sys);
		#1 reset_n = 1'b1;
		`CHK(stream_enable, 1'b1)
		chk_scale(16'h0816, 16'h0816, 16'h0816);
		// new automatic reference, stored at once
		r32 = rnd();
		ref_val = {5'h00, r32[10:0]} + 16'h0400;
		raw0 = {6'h00, r32[25:16]} + 16'h0800;
		ref_set = 1'b1;
		ref_set_value = ref_val;
		@(posedge clk_sys);
		#1 ref_set = 1'b0;
		wait_ms(1);
		`CHK(nv_count, 1)
		`CHK(nv_last[47:32], ref_val)
		// short hold is refused
		raw_reading = raw0;
		i_process_controller.press(30);
		wait_ms(5);
		`CHK(nv_count, 1)
		fork
			i_process_controller.press(50);
			begin
				wait_ms(8);
				`CHK(heartbeat, 1'b1)
				`CHK(led, 1'b1)
				`CHK(stream_enable, 1'b0)
				wait_ms(29);
				`CHK(heartbeat, 1'b0)
				`CHK(nv_count, 1)
			end
		join
		wait_ms(5);
		`CHK(nv_count, 2)
		`CHK(nv_last, {ref_val, ref_val, raw0})
		`CHK(stream_enable, 1'b1)
		chk_scale(16'hffff, ref_val, raw0);
		for (int i = 0; i < 6; i++) begin
			r32 = rnd();
			chk_scale({4'h0, r32[11:0]} + 16'h0001, ref_val, raw0);
		end
		// record loaded from storage
		nv_load_data = {ref_val, 16'h0a00, 16'h0500};
		nv_load_valid = 1'b1;
		@(posedge clk_sys);
		#1 nv_load_valid = 1'b0;
		chk_scale(16'h0123, 16'h0a00, 16'h0500);
		// enable low freezes storage and scaling
		clk_en = 1'b0;
		ref_set = 1'b1;
		raw_reading = 16'h0234;
		wait_ms(3);
		ref_set = 1'b0;
		`CHK(nv_count, 2)
		`CHK(scaled_reading, scale(16'h0123, 16'h0a00, 16'h0500))
		clk_en = 1'b1;
		wait_ms(1);
		`CHK(scaled_reading, scale(16'h0234, 16'h0a00, 16'h0500))
		// manual calibration through the trim input
		r32 = rnd();
		cal_mode_manual = 1'b1;
		manual_trim_potentiometer = {6'h00, r32[9:0]} + 16'h0700;
		raw1 = {6'h00, r32[25:16]} + 16'h0900;
		raw_reading = raw1;
		i_process_controller.press(25);
		wait_ms(5);
		`CHK(nv_count, 2)
		`CHK(stream_enable, 1'b0)
		i_process_controller.hb_half(n);
		i_process_controller.hb_half(n);
		`CHK(n, 500 * TICK)
		i_process_controller.press(25);
		wait_ms(5);
		`CHK(nv_count, 3)
		`CHK(nv_last, {ref_val, manual_trim_potentiometer, raw1})
		chk_scale(16'h0456, manual_trim_potentiometer, raw1);
		// sensor fault
		sensor_fault = 1'b1;
		@(posedge clk_sys);
		#1;
		`CHK(error_valid, 1'b1)
		@(posedge clk_sys);
		#1;
		`CHK(error_valid, 1'b0)
		`CHK(error_code, 8'h45)
		`CHK(analog_default, 1'b1)
		`CHK(analog_value, 16'h0000)
		`CHK(stream_enable, 1'b0)
		// one full fault period: three short and one long on time
		n = 0;
		repeat (2400 * TICK) begin
			@(posedge clk_sys);
			#1;
			n += heartbeat;
		end
		`CHK(n, 1400 * TICK)
		cal_mode_manual = 1'b0;
		fault_dark_sel = 1'b1;
		i_process_controller.press(50);
		wait_ms(5);
		`CHK(nv_count, 3)
		`CHK(heartbeat, 1'b0)
		`CHK(led, 1'b0)
		sensor_fault = 1'b0;
		wait_ms(1);
		`CHK(error_code, 8'h00)
		`CHK(analog_default, 1'b0)
		`CHK(stream_enable, 1'b1)
		end_of_test();
	end
endmodule

`default_nettype wire
